// ===== common/acq_pkg.sv
// Constants, register map and carrier types of the acquisition sync block.
// Assumes one 40 MHz clock and a host port with one-cycle strobes.
// Functional notes
// - Trigger edge polarity selectable, negative after reset
// - Active trigger starts exposure and readout
// - Status pin shows readout-idle or shutter, default shutter
// - Readout-idle low only while the array is read
// - Shutter-open high only while the shutter is open
// - Ready high until first exposure begins
// - Free run keeps ready low until halted
// - Frame count done returns ready high
// - Temperature lock output follows the loop lock
package acq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int EV_W = 4;

  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_FRAMES = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_EXPO = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RDLEN = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_FCOUNT = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h8;

  // Field positions
  localparam int CTRL_TRIG_POS = 0;
  localparam int CTRL_SEL_IDLE = 1;
  localparam int CTRL_FREE_RUN = 2;
  localparam int CTRL_TRIG_EN = 3;
  localparam int CMD_START = 0;
  localparam int CMD_HALT = 1;
  localparam int EV_DONE = 0;
  localparam int EV_FRAME = 1;
  localparam int EV_TRIG = 2;
  localparam int EV_LOCK = 3;

  // Values after reset and counts
  localparam logic [DATA_W-1:0] FRAMES_RST = 16'h0001;
  localparam logic [DATA_W-1:0] EXPO_RST = 16'h0010;
  localparam logic [DATA_W-1:0] RDLEN_RST = 16'h0010;
  localparam logic [DATA_W-1:0] CLEAN_CYCLES = 16'h0004;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CLEAN = 5'b00010,
    ST_WAIT_TRIG = 5'b00100,
    ST_EXPOSE = 5'b01000,
    ST_READOUT = 5'b10000
  } acq_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } acq_bus_req_type;

  typedef struct packed {
    logic trig_en;
    logic free_run;
    logic sel_idle;
    logic trig_pos;
  } acq_cfg_type;

  localparam acq_cfg_type CFG_RST = 4'h0;

endpackage : acq_pkg

// ===== rtl/acq_irq_ctrl.sv
// Sticky event status, mask and level interrupt.
// Assumes event pulses and write strobes are one cycle long.
module acq_irq_ctrl
  import acq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Events and software access
  input wire logic [EV_W-1:0] events,
  input wire logic stat_clr_wr,
  input wire logic mask_wr,
  input wire logic [EV_W-1:0] wdata,
  // Results
  output logic [EV_W-1:0] stat,
  output logic [EV_W-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic irq;
  } acq_irq_type;

  acq_irq_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    // A new event wins over a clear in the same cycle
    if (stat_clr_wr) begin
      s_next.stat = s_reg.stat & ~wdata;
    end
    s_next.stat = s_next.stat | events;
    if (mask_wr) begin
      s_next.mask = wdata;
    end
    s_next.irq = |(s_next.stat & s_next.mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stat = s_reg.stat;
  assign mask = s_reg.mask;
  assign irq = s_reg.irq;

endmodule // acq_irq_ctrl

// ===== rtl/acq_sync_top.sv
// Acquisition sequencer with trigger, status, ready and lock outputs.
// Assumes a host port with one-cycle strobes and synchronous pins.
module acq_sync_top
  import acq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire acq_bus_req_type bus_req,
  output logic [DATA_W-1:0] rdata,
  // External pins
  input wire logic ext_trig_in,
  input wire logic temp_loop_locked,
  output logic status_out,
  output logic ready_out,
  output logic shutter_open_out,
  output logic readout_idle_flag,
  output logic temp_lock_out,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    acq_state_type st;
    acq_cfg_type cfg;
    logic [DATA_W-1:0] frames_target;
    logic [DATA_W-1:0] expo_len;
    logic [DATA_W-1:0] read_len;
    logic [DATA_W-1:0] frames_done;
    logic [DATA_W-1:0] timer;
    logic [DATA_W-1:0] rdata;
    logic status;
    logic ready;
    logic shutter;
    logic idle;
    logic lock;
  } acq_core_type;

  acq_core_type s_reg, s_next;

  logic trig_pulse;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic wr_ctrl;
  logic wr_cmd;
  logic start_cmd;
  logic halt_cmd;
  logic last_frame;
  acq_state_type frame_entry;

  acq_trig_edge u_trig (
    .clk(clk),
    .rst(rst),
    .trig_in(ext_trig_in),
    .trig_pos(s_reg.cfg.trig_pos),
    .trig_pulse(trig_pulse)
  );

  acq_irq_ctrl u_irq (
    .clk(clk),
    .rst(rst),
    .events(events),
    .stat_clr_wr(bus_req.wr && bus_req.addr == ADDR_IRQ_STAT),
    .mask_wr(bus_req.wr && bus_req.addr == ADDR_IRQ_MASK),
    .wdata(bus_req.wdata[EV_W-1:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );

  assign wr_ctrl = bus_req.wr && bus_req.addr == ADDR_CTRL;
  assign wr_cmd = bus_req.wr && bus_req.addr == ADDR_CMD;
  assign start_cmd = wr_cmd && bus_req.wdata[CMD_START];
  assign halt_cmd = wr_cmd && bus_req.wdata[CMD_HALT];
  // A target of zero is taken as one frame
  assign last_frame = !s_reg.cfg.free_run &&
                      (s_reg.frames_done + 16'h0001 >= s_reg.frames_target);
  assign frame_entry = s_reg.cfg.trig_en ? ST_WAIT_TRIG : ST_EXPOSE;

  always_comb begin
    s_next = s_reg;
    events = '0;
    // Configuration only changes on its own write
    if (wr_ctrl) begin
      s_next.cfg = bus_req.wdata[3:0];
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_FRAMES: s_next.frames_target = bus_req.wdata;
        ADDR_EXPO: s_next.expo_len = bus_req.wdata;
        ADDR_RDLEN: s_next.read_len = bus_req.wdata;
        default: ;
      endcase
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (start_cmd) begin
          s_next.st = ST_CLEAN;
          s_next.timer = CLEAN_CYCLES - 16'h0001;
          s_next.frames_done = '0;
        end
      end
      ST_CLEAN: begin
        if (s_reg.timer == '0) begin
          s_next.st = frame_entry;
          s_next.timer = s_reg.expo_len;
        end else begin
          s_next.timer = s_reg.timer - 16'h0001;
        end
      end
      ST_WAIT_TRIG: begin
        if (trig_pulse) begin
          s_next.st = ST_EXPOSE;
          s_next.timer = s_reg.expo_len;
          events[EV_TRIG] = 1'b1;
        end
      end
      ST_EXPOSE: begin
        if (s_reg.timer == '0) begin
          s_next.st = ST_READOUT;
          s_next.timer = s_reg.read_len;
        end else begin
          s_next.timer = s_reg.timer - 16'h0001;
        end
      end
      ST_READOUT: begin
        if (s_reg.timer == '0) begin
          s_next.frames_done = s_reg.frames_done + 16'h0001;
          events[EV_FRAME] = 1'b1;
          if (last_frame) begin
            s_next.st = ST_IDLE;
            events[EV_DONE] = 1'b1;
          end else begin
            s_next.st = frame_entry;
            s_next.timer = s_reg.expo_len;
          end
        end else begin
          s_next.timer = s_reg.timer - 16'h0001;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // Halt aborts any frame, even mid readout
    if (halt_cmd) begin
      s_next.st = ST_IDLE;
    end

    // Ready falls at first exposure and rises only back in idle
    if (s_next.st == ST_IDLE) begin
      s_next.ready = 1'b1;
    end else if (s_next.st == ST_EXPOSE) begin
      s_next.ready = 1'b0;
    end
    s_next.shutter = s_next.st == ST_EXPOSE;
    s_next.idle = s_next.st != ST_READOUT;
    s_next.status = s_next.cfg.sel_idle ? s_next.idle
                                        : s_next.shutter;
    s_next.lock = temp_loop_locked;
    events[EV_LOCK] = temp_loop_locked && !s_reg.lock;

    s_next.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CTRL: s_next.rdata = {12'h000, s_reg.cfg};
        ADDR_FRAMES: s_next.rdata = s_reg.frames_target;
        ADDR_EXPO: s_next.rdata = s_reg.expo_len;
        ADDR_RDLEN: s_next.rdata = s_reg.read_len;
        ADDR_STATUS: s_next.rdata = {11'h000, s_reg.st != ST_IDLE,
                                     s_reg.lock, s_reg.shutter,
                                     s_reg.idle, s_reg.ready};
        ADDR_FCOUNT: s_next.rdata = s_reg.frames_done;
        ADDR_IRQ_STAT: s_next.rdata = {12'h000, irq_stat};
        ADDR_IRQ_MASK: s_next.rdata = {12'h000, irq_mask};
        default: s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg.st <= ST_IDLE;
      s_reg.cfg <= CFG_RST;
      s_reg.frames_target <= FRAMES_RST;
      s_reg.expo_len <= EXPO_RST;
      s_reg.read_len <= RDLEN_RST;
      s_reg.frames_done <= '0;
      s_reg.timer <= '0;
      s_reg.rdata <= '0;
      s_reg.status <= 1'b0;
      s_reg.ready <= 1'b1;
      s_reg.shutter <= 1'b0;
      s_reg.idle <= 1'b1;
      s_reg.lock <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign status_out = s_reg.status;
  assign ready_out = s_reg.ready;
  assign shutter_open_out = s_reg.shutter;
  assign readout_idle_flag = s_reg.idle;
  assign temp_lock_out = s_reg.lock;

  property p_trig_start;
    @(posedge clk) disable iff (rst)
    (s_reg.st == ST_WAIT_TRIG && trig_pulse && !halt_cmd)
      |=> shutter_open_out && !ready_out;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start exposure");

  property p_status_sel;
    @(posedge clk) disable iff (rst)
    ##1 status_out == (s_reg.cfg.sel_idle ? readout_idle_flag
                                          : shutter_open_out);
  endproperty
  a_status_sel: assert property (p_status_sel)
    else $error("status pin shows wrong source");

  property p_idle_flag;
    @(posedge clk) disable iff (rst)
    (s_reg.st == ST_EXPOSE && s_reg.timer == '0 && !halt_cmd)
      |=> !readout_idle_flag ##1
          (!readout_idle_flag || s_reg.read_len == '0 || $past(halt_cmd));
  endproperty
  a_idle_flag: assert property (p_idle_flag)
    else $error("readout idle flag not low during readout");

  property p_shutter;
    @(posedge clk) disable iff (rst)
    shutter_open_out |-> s_reg.st == ST_EXPOSE && readout_idle_flag;
  endproperty
  a_shutter: assert property (p_shutter)
    else $error("shutter open outside exposure");

  property p_ready_clean;
    @(posedge clk) disable iff (rst)
    (s_reg.st == ST_IDLE && start_cmd && !halt_cmd)
      |=> ready_out [*4];
  endproperty
  a_ready_clean: assert property (p_ready_clean)
    else $error("ready fell during cleaning");

  property p_free_run;
    @(posedge clk) disable iff (rst)
    (s_reg.cfg.free_run && !wr_ctrl && !halt_cmd &&
     s_reg.st == ST_READOUT) |=> !ready_out;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("ready rose in free run");

  property p_count_done;
    @(posedge clk) disable iff (rst)
    (s_reg.st == ST_READOUT && s_reg.timer == '0 && last_frame)
      |=> ready_out && irq_stat[EV_DONE];
  endproperty
  a_count_done: assert property (p_count_done)
    else $error("ready not high after last frame");

  property p_lock;
    @(posedge clk) disable iff (rst)
    $rose(temp_loop_locked) |=> temp_lock_out && irq_stat[EV_LOCK];
  endproperty
  a_lock: assert property (p_lock)
    else $error("temperature lock not reported");

  property p_cfg_hold;
    @(posedge clk) disable iff (rst)
    !wr_ctrl |=> $stable(s_reg.cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed without a write");

  property p_halt;
    @(posedge clk) disable iff (rst)
    halt_cmd |=> ready_out && !shutter_open_out && readout_idle_flag;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not return to idle");

  property p_wait_trig;
    @(posedge clk) disable iff (rst)
    (s_reg.st == ST_WAIT_TRIG && !trig_pulse && !halt_cmd)
      |=> s_reg.st == ST_WAIT_TRIG && !shutter_open_out;
  endproperty
  a_wait_trig: assert property (p_wait_trig)
    else $error("exposure began without a trigger");

  property p_expose_ready;
    @(posedge clk) disable iff (rst)
    shutter_open_out |-> !ready_out;
  endproperty
  a_expose_ready: assert property (p_expose_ready)
    else $error("ready high during exposure");

  property p_lock_follow;
    @(posedge clk) disable iff (rst)
    temp_loop_locked |=> temp_lock_out;
  endproperty
  a_lock_follow: assert property (p_lock_follow)
    else $error("lock output missed a locked loop");

endmodule // acq_sync_top

// ===== rtl/acq_trig_edge.sv
// Edge detector for the external trigger input.
// Assumes the trigger level is already synchronous to clk.
module acq_trig_edge
  import acq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Trigger
  input wire logic trig_in,
  input wire logic trig_pos,
  output logic trig_pulse
);

  typedef struct packed {
    logic last;
    logic pulse;
  } acq_edge_type;

  acq_edge_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.last = trig_in;
    s_next.pulse = trig_pos ? (trig_in && !s_reg.last)
                            : (!trig_in && s_reg.last);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{last: 1'b1, pulse: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign trig_pulse = s_reg.pulse;

  property p_edge_pol;
    @(posedge clk) disable iff (rst)
    (!trig_pos && $fell(trig_in)) |=> trig_pulse;
  endproperty
  a_edge_pol: assert property (p_edge_pol)
    else $error("negative trigger edge not detected");

  property p_edge_pos;
    @(posedge clk) disable iff (rst)
    (trig_pos && $rose(trig_in)) |=> trig_pulse;
  endproperty
  a_edge_pos: assert property (p_edge_pos)
    else $error("positive trigger edge not detected");

endmodule // acq_trig_edge

// ===== test/acq_ext_model.sv
// Partner model: external trigger source and temperature control loop.
// Assumes its tasks are called just after a rising clk edge.
module acq_ext_model (
  // Clock
  input wire logic clk,
  // Pins toward the block
  output logic trig,
  output logic locked
);
  timeunit 1ns;
  timeprecision 1ps;

  // The trigger line has a pull-up, so an idle source leaves it high
  initial begin
    trig = 1'b1;
    locked = 1'b0;
  end

  // A delay of some cycles lets the source answer slowly
  task automatic drive_trig(input logic v, input int delay);
    repeat (delay) @(posedge clk);
    trig <= v;
  endtask

  task automatic set_lock(input logic v);
    locked <= v;
  endtask
endmodule // acq_ext_model

// ===== test/tb.sv
// Self-checking bench for the acquisition sync block.
// Assumes one 40 MHz clock and the partner model beside the block.
module tb
  import acq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst;
  acq_bus_req_type req;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  logic [15:0] k;
  logic trig;
  logic locked;
  logic status_out;
  logic ready_out;
  logic shutter_open_out;
  logic readout_idle_flag;
  logic temp_lock_out;
  logic irq;
  logic [4:0] pins;
  int n_mismatch;
  int compares;
  int cyc;
  int p;

  assign pins = {irq, temp_lock_out, readout_idle_flag, shutter_open_out,
    ready_out};

  acq_sync_top acq_sync_top_i (
    .clk(clk),
    .rst(rst),
    .bus_req(req),
    .rdata(rdata),
    .ext_trig_in(trig),
    .temp_loop_locked(locked),
    .status_out(status_out),
    .ready_out(ready_out),
    .shutter_open_out(shutter_open_out),
    .readout_idle_flag(readout_idle_flag),
    .temp_lock_out(temp_lock_out),
    .irq(irq)
  );

  acq_ext_model acq_ext_model_i (
    .clk(clk),
    .trig(trig),
    .locked(locked)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ends the run as failed after 20000 cycles if a wait below never ends
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // One idle cycle after each strobe keeps every strobe a single pulse
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic wt(input int s, input logic v);
    int i;
    for (i = 0; i < 300 && pins[s] !== v; i++) begin
      @(posedge clk);
    end
    chk({15'h0, pins[s]}, {15'h0, v}, "pin wait");
  endtask

  initial begin
    req = '0;
    rst = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({12'h0, status_out, ready_out, shutter_open_out, readout_idle_flag},
      16'h0005, "reset pins");
    rd(ADDR_CTRL);
    chk(d, 16'h0000, "ctrl reset");
    rd(ADDR_FRAMES);
    chk(d, 16'h0001, "frames reset");
    rd(4'hF);
    chk(d, 16'h0000, "unmapped read");
    rd(ADDR_STATUS);
    chk(d, 16'h0003, "status reset");
    $display("test reset done");

    wr(ADDR_FRAMES, 16'h0002);
    wr(ADDR_EXPO, 16'h0002);
    wr(ADDR_RDLEN, 16'h0003);
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_CMD, 16'h0001);
    wt(0, 1'b0);
    chk({14'h0, status_out, shutter_open_out}, 16'h0003,
      "expose");
    wt(2, 1'b0);
    chk({15'h0, shutter_open_out}, 16'h0000, "shutter shut");
    wt(2, 1'b1);
    wt(2, 1'b0);
    chk({15'h0, ready_out}, 16'h0000, "ready mid run");
    wt(0, 1'b1);
    wt(4, 1'b1);
    rd(ADDR_FCOUNT);
    chk(d, 16'h0002, "frame count");
    wr(ADDR_IRQ_STAT, 16'h000F);
    wt(4, 1'b0);
    $display("test counted done");

    wr(ADDR_CTRL, 16'h0006);
    rd(ADDR_CTRL);
    chk(d, 16'h0006, "ctrl hold");
    chk({15'h0, status_out}, 16'h0001, "idle shown");
    wr(ADDR_CMD, 16'h0001);
    wt(0, 1'b0);
    wt(2, 1'b0);
    chk({15'h0, status_out}, 16'h0000, "idle low");
    k = 16'h0;
    repeat (100) begin
      @(posedge clk);
      if (ready_out !== 1'b0) begin
        k++;
      end
    end
    chk(k, 16'h0000, "free run ready");
    wr(ADDR_CMD, 16'h0002);
    @(posedge clk);
    chk({15'h0, ready_out}, 16'h0001, "halt ready");
    $display("test free run done");

    // Wrong edge first, then the chosen edge after a slow source
    for (p = 0; p < 2; p++) begin
      acq_ext_model_i.drive_trig(p[0], 0);
      wr(ADDR_CTRL, 16'(8 + p));
      wr(ADDR_CMD, 16'h0001);
      repeat (20) @(posedge clk);
      chk({15'h0, shutter_open_out}, 16'h0000, "no trigger");
      acq_ext_model_i.drive_trig(~p[0], 0);
      repeat (10) @(posedge clk);
      chk({15'h0, shutter_open_out}, 16'h0000, "wrong edge");
      acq_ext_model_i.drive_trig(p[0], 3);
      wt(1, 1'b1);
      chk({15'h0, ready_out}, 16'h0000, "trig ready");
      wr(ADDR_CMD, 16'h0002);
    end
    $display("test trigger done");

    acq_ext_model_i.set_lock(1'b1);
    wt(3, 1'b1);
    rd(ADDR_IRQ_STAT);
    chk({15'h0, d[EV_LOCK]}, 16'h0001, "lock event");
    chk({15'h0, irq}, 16'h0000, "masked irq");
    acq_ext_model_i.set_lock(1'b0);
    wt(3, 1'b0);
    $display("test lock done");
    conclude();
  end
endmodule // tb
